//--- rtl/bds_ctrl.v
// Battery detect sampling controller with heavy-load mode and interrupts.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "bds_defs.vh"

module bds_ctrl #(
    parameter [15:0] SAMPLE_CYCLES = `BDS_SAMPLE_CYCLES,
    parameter [15:0] INSTR_CYCLES  = `BDS_INSTR_CYCLES
) (
    input  wire       sys_clk,
    input  wire       nrst,
    input  wire [9:0] reg_addr,
    input  wire [3:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [3:0] reg_rdata,
    input  wire       tick_2hz,
    input  wire       main_cmp_low,
    input  wire       sub_cmp_low,
    output reg        detector_enable,
    output wire       heavy_load_active,
    output reg  [2:0] detect_threshold,
    output wire       irq
);

    // Sequencer states, one-hot.
    localparam [2:0] ST_IDLE     = 3'b001;
    localparam [2:0] ST_INITIAL  = 3'b010;
    localparam [2:0] ST_PERIODIC = 3'b100;

    // Address match, used by every register decode below.
    function hit;
        input [9:0] addr;
        input [9:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // The sample counter is loaded and tested from two states; keeping
    // the arithmetic in one place stops the two sample kinds drifting
    // apart by a cycle.
    // A length of zero wraps to the largest count, so lengths start at one.
    // Reload value for a sample that keeps the detector on len cycles.
    function [15:0] cnt_load;
        input [15:0] len;
        begin
            cnt_load = len - 16'h0001;
        end
    endfunction

    // True in the last cycle of a running sample.
    function cnt_last;
        input [15:0] value;
        begin
            cnt_last = (value == 16'h0000);
        end
    endfunction

    // One step down of the running sample counter.
    function [15:0] cnt_step;
        input [15:0] value;
        begin
            cnt_step = value - 16'h0001;
        end
    endfunction

    reg        heavy_load_mode;
    reg        detect_on;
    reg        detect_result;
    reg        sub_detect_result;
    reg [2:0]  state;
    reg [15:0] cnt;
    reg [2:0]  irq_status;
    reg [2:0]  irq_enable;

    reg [2:0]  next_state;
    reg [15:0] next_cnt;
    reg        sample_done;
    reg        next_detector_enable;

    wire [1:0] cmp_sync;
    wire       main_low;
    wire       sub_low;

    // The comparators sit in the analog domain and are sampled twice first.
    // A capture therefore sees the comparator as it stood two cycles
    // earlier; the sample lengths already cover that delay.
    bds_sync #(
        .WIDTH   (2)
    ) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .async_in({sub_cmp_low, main_cmp_low}),
        .sync_out(cmp_sync)
    );

    assign main_low = cmp_sync[0];
    assign sub_low  = cmp_sync[1];

    // Write strobes decoded per register.
    wire wr_heavy  = reg_wr & hit(reg_addr, `BDS_ADDR_HEAVY);
    wire wr_detect = reg_wr & hit(reg_addr, `BDS_ADDR_DETECT);
    wire wr_clear  = reg_wr & hit(reg_addr, `BDS_ADDR_IRQ_CLEAR);
    wire wr_enable = reg_wr & hit(reg_addr, `BDS_ADDR_IRQ_ENABLE);

    // rising edge
    // Only a zero-to-one change of the mode bit starts an initial sample.
    wire heavy_rise = wr_heavy & reg_wdata[`BDS_HEAVY_MODE_BIT]
                    & ~heavy_load_mode;

    // A write of zero to the mode bit ends an initial sample at once.
    wire heavy_clear = wr_heavy & ~reg_wdata[`BDS_HEAVY_MODE_BIT];

    // forced heavy mode
    // A low sub result keeps the device in heavy-load mode on its own.
    // The forced mode starts no initial sample; the next 2 Hz tick takes
    // the first periodic one.
    assign heavy_load_active = heavy_load_mode | sub_detect_result;

    // load on clear
    // Turning continuous detection off captures the comparators right then.
    wire detect_off = wr_detect & ~reg_wdata[`BDS_DETECT_BIT] & detect_on;

    // Any event that writes the detector latches.
    wire capture = sample_done | detect_off;

    // A write of one while the bit is already one changes nothing here
    // and, by the edge detect above, starts no new sample either.
    // mode bit
    // Heavy-load mode follows the last write; it is a plain stored bit.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            heavy_load_mode <= `BDS_HEAVY_RESET;
        end else if (wr_heavy) begin
            heavy_load_mode <= reg_wdata[`BDS_HEAVY_MODE_BIT];
        end
    end

    // detect control
    // The written detect bit and the threshold are stored apart from the
    // result, so software can never read back what it wrote to that bit.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            detect_on        <= `BDS_DETECT_RESET;
            detect_threshold <= `BDS_THRESH_RESET;
        end else if (wr_detect) begin
            detect_on        <= reg_wdata[`BDS_DETECT_BIT];
            detect_threshold <=
                reg_wdata[`BDS_THRESH_MSB:`BDS_THRESH_LSB];
        end
    end

    // Sampling sequencer: an initial sample when software sets the mode bit, then one per tick.
    always @* begin
        next_state  = state;
        next_cnt    = cnt;
        sample_done = 1'b0;
        case (state)
            ST_IDLE: begin
                // An initial sample wins over a tick in the same cycle;
                // the tick is not kept, the next period samples again.
                if (heavy_rise) begin
                    next_state = ST_INITIAL;
                    next_cnt   = cnt_load(INSTR_CYCLES);
                end else if (heavy_load_active & tick_2hz) begin
                    next_state = ST_PERIODIC;
                    next_cnt   = cnt_load(SAMPLE_CYCLES);
                end
            end
            ST_INITIAL: begin
                // A write of zero ends the sample with no capture, so the
                // latch keeps the last result that was taken in full.
                if (heavy_clear) begin
                    next_state = ST_IDLE;
                    next_cnt   = 16'h0000;
                end else if (cnt_last(cnt)) begin
                    sample_done = 1'b1;
                    next_state  = ST_IDLE;
                end else begin
                    next_cnt = cnt_step(cnt);
                end
            end
            ST_PERIODIC: begin
                if (!heavy_load_active) begin
                    // plain release
                    // Leaving heavy-load mode drops the sample without a
                    // capture; no extra software step is needed.
                    next_state = ST_IDLE;
                    next_cnt   = 16'h0000;
                end else if (cnt_last(cnt)) begin
                    sample_done = 1'b1;
                    next_state  = ST_IDLE;
                end else begin
                    next_cnt = cnt_step(cnt);
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt   = 16'h0000;
            end
        endcase
    end

    // Sequencer registers.
    // State and counter share one process so they never disagree.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cnt   <= 16'h0000;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // The analog detectors are powered while a sample runs or while
    // software holds detection on; they draw current, so this is never
    // left high by the sequencer itself.
    // A write in this cycle already counts, so the detector powers up one
    // cycle after the write edge, the same delay as a sequencer sample.
    // continuous run
    always @* begin
        next_detector_enable = (next_state != ST_IDLE) | detect_on;
        if (wr_detect) begin
            next_detector_enable = (next_state != ST_IDLE)
                                 | reg_wdata[`BDS_DETECT_BIT];
        end
    end

    // Enable register; the flop keeps decode glitches off the power switch.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            detector_enable <= 1'b0;
        end else begin
            detector_enable <= next_detector_enable;
        end
    end

    // latch hold
    // Both latches move only on a capture and hold their value otherwise.
    // The sub latch is taken at every capture as well, so both results
    // always come from one and the same instant.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            detect_result     <= `BDS_LATCH_RESET;
            sub_detect_result <= `BDS_LATCH_RESET;
        end else if (capture) begin
            detect_result     <= main_low;
            sub_detect_result <= sub_low;
        end
    end

    // Interrupt events derived from each capture.
    // Only a change into the low state raises a supply event, so a supply
    // that stays low asks for service once, not on every sample.
    wire [2:0] events;
    assign events[`BDS_EV_CAPTURE]  = capture;
    assign events[`BDS_EV_SUB_LOW]  = capture & sub_low & ~sub_detect_result;
    assign events[`BDS_EV_MAIN_LOW] = capture & main_low & ~detect_result;

    // Sticky status: a new event in the cycle of its clear stays set.
    // A bit that software never clears stays set, and the line stays high
    // for as long as that bit is enabled.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= `BDS_IRQ_RESET;
        end else if (wr_clear) begin
            irq_status <= (irq_status & ~reg_wdata[2:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // Interrupt enable register.
    // Enables gate only the line; status bits set regardless, so software
    // may also poll the status word with every enable cleared.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_enable <= `BDS_IRQ_RESET;
        end else if (wr_enable) begin
            irq_enable <= reg_wdata[2:0];
        end
    end

    // Level interrupt, high while any enabled status bit is set.
    assign irq = |(irq_status & irq_enable);

    // Read data appear only in the cycle after the read strobe; other
    // cycles and unmapped addresses return zero.
    // The clear register is write-only and reads as zero, so software
    // cannot tell a pending clear from a finished one.
    // The detect word never shows the written on/off bit: it shares one
    // position with the latched result, so a read-modify-write of this
    // word would switch detection off whenever the last result was a
    // normal supply.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 4'h0;
        end else if (reg_rd) begin
            if (hit(reg_addr, `BDS_ADDR_HEAVY)) begin
                reg_rdata <= {heavy_load_mode, sub_detect_result, 2'b00};
            end else if (hit(reg_addr, `BDS_ADDR_DETECT)) begin
                reg_rdata <= {detect_result, detect_threshold};
            end else if (hit(reg_addr, `BDS_ADDR_IRQ_STATUS)) begin
                reg_rdata <= {1'b0, irq_status};
            end else if (hit(reg_addr, `BDS_ADDR_IRQ_ENABLE)) begin
                reg_rdata <= {1'b0, irq_enable};
            end else begin
                reg_rdata <= 4'h0;
            end
        end else begin
            reg_rdata <= 4'h0;
        end
    end

endmodule // bds_ctrl

//--- rtl/bds_defs.vh
// Constants for the battery detect sampling controller.
`ifndef BDS_DEFS_VH
`define BDS_DEFS_VH

// Register word indices on the 10-bit register port.
`define BDS_ADDR_HEAVY        10'h2E6
`define BDS_ADDR_DETECT       10'h2FF
`define BDS_ADDR_IRQ_STATUS   10'h300
`define BDS_ADDR_IRQ_CLEAR    10'h301
`define BDS_ADDR_IRQ_ENABLE   10'h302

// Field positions in the heavy-load register.
`define BDS_HEAVY_MODE_BIT    3
`define BDS_SUB_RESULT_BIT    2

// Field positions in the detect control and result register.
`define BDS_DETECT_BIT        3
`define BDS_THRESH_MSB        2
`define BDS_THRESH_LSB        0

// Interrupt status bit positions.
`define BDS_EV_CAPTURE        0
`define BDS_EV_SUB_LOW        1
`define BDS_EV_MAIN_LOW       2

// Reset values.
`define BDS_HEAVY_RESET       1'b0
`define BDS_DETECT_RESET      1'b0
`define BDS_THRESH_RESET      3'h0
`define BDS_LATCH_RESET       1'b0
`define BDS_IRQ_RESET         3'h0

// Timing: clock period and detector on-time of a periodic sample.
`define BDS_CLK_PERIOD_NS     4
`define BDS_SAMPLE_TIME_NS    100000
// Sys clock cycles of one periodic sample: 100 us in 4 ns steps.
`define BDS_SAMPLE_CYCLES     16'h61A8
// Sys clock cycles in one CPU instruction cycle; a plain default.
`define BDS_INSTR_CYCLES      16'h0004

`endif

//--- rtl/bds_sync.v
// Two-stage synchroniser for the asynchronous comparator levels.
`timescale 1ns/1ns

module bds_sync #(
    parameter WIDTH = 2
) (
    input  wire             sys_clk,
    input  wire             nrst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] stable;

    // Only the second stage is visible outside; the first may be metastable.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta   <= {WIDTH{1'b0}};
            stable <= {WIDTH{1'b0}};
        end else begin
            meta   <= async_in;
            stable <= meta;
        end
    end

    assign sync_out = stable;

endmodule // bds_sync

//--- tb/bds_cmp_model.sv
// Behavioural model of the two analog supply comparators.
`timescale 1ns/1ns
module bds_cmp_model (
    input  logic sys_clk,
    input  logic detector_enable,
    input  logic supply_low_main,
    input  logic supply_low_sub,
    output logic main_cmp_low,
    output logic sub_cmp_low
);
    logic junk = 1'b0;
    // An unpowered comparator gives no answer, so it toggles every cycle.
    always @(posedge sys_clk) begin
        junk <= ~junk;
    end
    assign main_cmp_low = detector_enable ? supply_low_main : junk;
    assign sub_cmp_low  = detector_enable ? supply_low_sub : ~junk;
endmodule // bds_cmp_model

//--- tb/bds_ctrl_sva.sv
// Port-level checker for the battery detect sampling controller.
`timescale 1ns/1ns
module bds_ctrl_sva #(
    parameter [15:0] SAMPLE_CYCLES = 16'h61A8,
    parameter [15:0] INSTR_CYCLES  = 16'h0004
) (
    input logic       sys_clk,
    input logic       nrst,
    input logic [9:0] reg_addr,
    input logic [3:0] reg_wdata,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [3:0] reg_rdata,
    input logic       tick_2hz,
    input logic       main_cmp_low,
    input logic       sub_cmp_low,
    input logic       detector_enable,
    input logic       heavy_load_active,
    input logic [2:0] detect_threshold,
    input logic       irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Counts below assume the bench values 4 and 8.
    wire w_hl = reg_wr && reg_addr == 10'h2E6 && reg_wdata[3];
    wire w_dt = reg_wr && reg_addr == 10'h2FF;
    wire start = w_hl && !heavy_load_active && !detector_enable;
    wire tk = tick_2hz && heavy_load_active && !detector_enable && !reg_wr;
    property p_rd_stand;
        !$past(reg_rd) |-> reg_rdata == 4'h0;
    endproperty
    a_rd_stand: assert property (p_rd_stand)
        else $error("read data outside its cycle");
    property p_hl_set;
        w_hl |=> heavy_load_active;
    endproperty
    a_hl_set: assert property (p_hl_set)
        else $error("heavy load mode not set");
    property p_init;
        start |=> detector_enable[*4] ##1 !detector_enable;
    endproperty
    a_init: assert property (p_init)
        else $error("initial sample length wrong");
    property p_periodic;
        tk |=> detector_enable[*8] ##1 !detector_enable;
    endproperty
    a_periodic: assert property (p_periodic)
        else $error("periodic sample length wrong");
    property p_thr;
        reg_rd && reg_addr == 10'h2FF |=>
            reg_rdata[2:0] == $past(detect_threshold);
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold read back wrong");
    property p_on;
        w_dt && reg_wdata[3] |=> detector_enable;
    endproperty
    a_on: assert property (p_on)
        else $error("detection did not switch on");
    property p_off;
        w_dt && !reg_wdata[3] && !heavy_load_active |=> !detector_enable;
    endproperty
    a_off: assert property (p_off)
        else $error("detection did not switch off");
    property p_hl_rd;
        reg_rd && reg_addr == 10'h2E6 |=> reg_rdata[1:0] == 2'h0 &&
            (reg_rdata[3] | reg_rdata[2]) == $past(heavy_load_active);
    endproperty
    a_hl_rd: assert property (p_hl_rd)
        else $error("heavy load register read wrong");
    c_init: cover property (start);
    c_periodic: cover property (tk);
    c_irq: cover property ($rose(irq));
endmodule // bds_ctrl_sva
bind bds_ctrl bds_ctrl_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES),
    .INSTR_CYCLES(INSTR_CYCLES)) i_sva (.*);

//--- tb/testbench.sv
// Self-checking bench for the battery detect sampling controller.
`timescale 1ns/1ns
module testbench;
    logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [3:0] reg_wdata = 4'h0, reg_rdata;
    logic tick_2hz = 1'b0, lo_main = 1'b1, lo_sub = 1'b0;
    logic main_cmp_low, sub_cmp_low, detector_enable, heavy_load_active, irq;
    logic [2:0] detect_threshold;
    int err_total = 0, checked = 0;
    bds_ctrl #(.SAMPLE_CYCLES(16'h0008), .INSTR_CYCLES(16'h0004)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tick_2hz(tick_2hz),
        .main_cmp_low(main_cmp_low), .sub_cmp_low(sub_cmp_low),
        .detector_enable(detector_enable),
        .heavy_load_active(heavy_load_active),
        .detect_threshold(detect_threshold), .irq(irq));
    bds_cmp_model i_cmp (.sys_clk(sys_clk), .detector_enable(detector_enable),
        .supply_low_main(lo_main), .supply_low_sub(lo_sub),
        .main_cmp_low(main_cmp_low), .sub_cmp_low(sub_cmp_low));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    task tally_and_finish;
        $display("errors=%0d checks=%0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [9:0] a, input logic [3:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rd(input logic [9:0] a, input logic [3:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task tick;
        @(posedge sys_clk) tick_2hz <= 1'b1;
        @(posedge sys_clk) tick_2hz <= 1'b0;
    endtask
    // Bounded wait for a sample to finish; a hang ends the run.
    task wait_idle;
        int n;
        repeat (2) @(posedge sys_clk);
        #1;
        for (n = 0; n < 40 && detector_enable !== 1'b0; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (detector_enable !== 1'b0) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, detector_enable,
                     1'b0);
            tally_and_finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(10'h2E6, 4'h0);
        rd(10'h2FF, 4'h0);
        rd(10'h100, 4'h0);
        wr(10'h2E6, 4'h7);
        rd(10'h2E6, 4'h0);
        wr(10'h2E6, 4'h8);
        wait_idle;
        rd(10'h2E6, 4'h8);
        rd(10'h2FF, 4'h8);
        lo_main <= 1'b0;
        tick;
        wait_idle;
        rd(10'h2FF, 4'h0);
        wr(10'h2E6, 4'h0);
        rd(10'h2E6, 4'h0);
        lo_main <= 1'b1;
        wr(10'h2FF, 4'hD);
        repeat (4) @(posedge sys_clk);
        wr(10'h2FF, 4'h5);
        rd(10'h2FF, 4'hD);
        chk({1'b0, detect_threshold}, 4'h5);
        lo_main <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(10'h2FF, 4'hD);
        lo_sub <= 1'b1;
        wr(10'h2FF, 4'h8);
        repeat (4) @(posedge sys_clk);
        wr(10'h2FF, 4'h0);
        rd(10'h2E6, 4'h4);
        chk({3'h0, heavy_load_active}, 4'h1);
        lo_sub <= 1'b0;
        tick;
        wait_idle;
        rd(10'h2E6, 4'h0);
        rd(10'h300, 4'h7);
        wr(10'h301, 4'h7);
        rd(10'h300, 4'h0);
        wr(10'h302, 4'h1);
        chk({3'h0, irq}, 4'h0);
        wr(10'h2FF, 4'h8);
        repeat (4) @(posedge sys_clk);
        wr(10'h2FF, 4'h0);
        #1 chk({3'h0, irq}, 4'h1);
        rd(10'h300, 4'h1);
        rd(10'h302, 4'h1);
        rd(10'h301, 4'h0);
        wr(10'h302, 4'h0);
        #1 chk({3'h0, irq}, 4'h0);
        wr(10'h302, 4'h1);
        wr(10'h301, 4'h1);
        #1 chk({3'h0, irq}, 4'h0);
        tally_and_finish;
    end
endmodule // testbench
